/* ebcs_pkg.sv */
// Shared constants and carrier types for the byte-lane and chip-select block
package ebcs_pkg;
    localparam int CS_NUM  = 5;
    localparam int SEG_W   = 8;
    localparam int ADDR_W  = 24;
    localparam int DATA_W  = 16;

    // Reset-latched segment line codes
    localparam logic [1:0] SAL_TWO   = 2'h3;
    localparam logic [1:0] SAL_EIGHT = 2'h2;
    localparam logic [1:0] SAL_NONE  = 2'h1;
    localparam logic [1:0] SAL_FOUR  = 2'h0;
    localparam logic [7:0] SEG_MASK_TWO   = 8'h03;
    localparam logic [7:0] SEG_MASK_EIGHT = 8'hff;
    localparam logic [7:0] SEG_MASK_NONE  = 8'h00;
    localparam logic [7:0] SEG_MASK_FOUR  = 8'h0f;

    // Reset-latched chip-select count codes
    localparam logic [1:0] CSL_FIVE  = 2'h3;
    localparam logic [1:0] CSL_NONE  = 2'h2;
    localparam logic [1:0] CSL_TWO   = 2'h1;
    localparam logic [1:0] CSL_THREE = 2'h0;
    localparam logic [4:0] CS_MASK_FIVE  = 5'h1f;
    localparam logic [4:0] CS_MASK_NONE  = 5'h00;
    localparam logic [4:0] CS_MASK_TWO   = 5'h03;
    localparam logic [4:0] CS_MASK_THREE = 5'h07;

    localparam int SEG_LSB = 16;
    localparam logic LANE_OFF_RST = 1'b1;

    typedef struct packed {
        logic [1:0] segment_line_select;
        logic [1:0] chip_select_count_sel;
        logic       bus16;
        logic       single_chip;
    } ebcs_strap_t;

    localparam ebcs_strap_t STRAP_RST = '{SAL_TWO, CSL_FIVE, 1'b1, 1'b0};

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              write;
        logic              word;
        logic              internal;
    } ebcs_acc_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b10
    } ebcs_state_t;
endpackage

/* ebcs_byte_cs.sv */
// Byte lanes, segment address lines and chip selects of the external bus
`timescale 1ns/1ns
// Contract
// - On 16-bit bus upper lane uses high byte enable, lower lane uses A0.
// - Split strobe config turns write pin and enable pin into byte write strobes.
// - Byte writes to 16-bit device drive the byte onto both data halves.
// - Byte reads from 16-bit device read the word and keep the addressed byte.
// - Demux address port is released when no window selects demultiplexed mode.
// - Lane-off bit 0 drives high byte enable pin; 1 leaves it general I/O.
// - After reset lane-off bit is clear for 16-bit strap, set otherwise.
// - Configured segment lines extend the 16-bit address during external accesses.
// - Segment codes: 11 two lines, 10 eight, 01 none, 00 four.
// - Chip-select codes: 11 five, 10 none, 01 two, 00 three.
// - Chip selects leave on their own port without external decoder.
// - A select is low for accesses inside its window, high outside.
// - No select asserts for internal accesses.
// - Qualify bits w/r: 00 address, 01 read, 10 write, 11 read/write.
// - Address select changes only at latch strobe fall, glitch free.
// - Read/write selects follow the command strobe including its delay.
// - Read select in reads, write select in writes, write if any byte strobe.
// - After reset with single-chip strap clear, first select acts as address select for the first fetch.
// - During reset selected lines pulled up, then driven; others float.
// - During hold, push-pull selects pulled up and open-drain ones float.
// - Words on 8-bit bus become two byte cycles, low byte first.
module ebcs_byte_cs (
    input  wire logic                clk,                    // Clock
    input  wire logic                nrst,                   // Async reset
    input  wire logic                strap_sample,           // Reset sequence active
    input  wire ebcs_pkg::ebcs_strap_t strap,                // Reset config pins
    input  wire logic                acc_valid,              // Access request
    input  wire ebcs_pkg::ebcs_acc_t acc,                    // Access payload
    input  wire logic [4:0]          win_hit,                // Window match, one-hot
    input  wire logic [4:0]          win_demux,              // Window demux modes
    input  wire logic [4:0]          sel_write_qualify_bit,  // Per window
    input  wire logic [4:0]          sel_read_qualify_bit,   // Per window
    input  wire logic                cyc_bus16,              // Window data width
    input  wire logic                split_write_strobe_cfg, // Split strobe mode
    input  wire logic                lane_off_we,            // Software write
    input  wire logic                lane_off_wdata,         // Written value
    input  wire logic                ale_fall,               // Latch strobe fall
    input  wire logic                rd_strobe,              // Read command level
    input  wire logic                wr_strobe,              // Write command level
    input  wire logic                cyc_done,               // Cycle end pulse
    input  wire logic [15:0]         data_in,                // Bus data in
    input  wire logic                hold_acknowledge_n,     // Bus hold granted
    input  wire logic [4:0]          cs_open_drain,          // Pin driver mode
    output logic                     acc_ready,              // Accepting request
    output logic                     rd_valid,               // Read data pulse
    output logic [15:0]              rd_data,                // Read data
    output logic                     cyc_req,                // Cycle wanted
    output logic                     cyc_write,              // Cycle is write
    output logic [23:0]              cyc_addr,               // Cycle address
    output logic                     upper_lane_enable_off,  // Lane-off bit
    output logic                     high_byte_enable_n,     // Pin out
    output logic                     high_byte_enable_oe,    // Pin enable
    output logic                     write_low_strobe_n,     // Write pin out
    output logic [15:0]              data_out,               // Bus data out
    output logic                     data_oe,                // Bus data enable
    output logic [7:0]               seg_addr,               // Segment lines
    output logic [7:0]               seg_oe,                 // Segment enables
    output logic [4:0]               chip_select_n,          // Select lines
    output logic [4:0]               chip_select_oe,         // Select enables
    output logic [4:0]               chip_select_pullup,     // Pullup enables
    output logic [15:0]              demux_address_port,     // Intra-segment addr
    output logic                     demux_port_oe           // Port driven
);
    // ------------------------------------------------------------
    // Reset configuration latch
    // ------------------------------------------------------------
    ebcs_pkg::ebcs_strap_t strap_r;
    logic                  lane_off_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_r <= ebcs_pkg::STRAP_RST;
        end else if (strap_sample) begin
            strap_r <= strap;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lane_off_r <= ebcs_pkg::LANE_OFF_RST;
        end else if (strap_sample) begin
            lane_off_r <= !strap.bus16;
        end else if (lane_off_we) begin
            lane_off_r <= lane_off_wdata;
        end
    end
    assign upper_lane_enable_off = lane_off_r;

    wire [7:0] seg_mask;
    wire [4:0] cs_mask;
    assign seg_mask = (strap_r.segment_line_select == ebcs_pkg::SAL_TWO)   ? ebcs_pkg::SEG_MASK_TWO :
                      (strap_r.segment_line_select == ebcs_pkg::SAL_EIGHT) ? ebcs_pkg::SEG_MASK_EIGHT :
                      (strap_r.segment_line_select == ebcs_pkg::SAL_NONE)  ? ebcs_pkg::SEG_MASK_NONE :
                      ebcs_pkg::SEG_MASK_FOUR;
    // Uses live strap during reset so pullups track the pins at once
    wire [1:0] csl_sel;
    assign csl_sel = strap_sample ? strap.chip_select_count_sel : strap_r.chip_select_count_sel;
    assign cs_mask = (csl_sel == ebcs_pkg::CSL_FIVE) ? ebcs_pkg::CS_MASK_FIVE :
                     (csl_sel == ebcs_pkg::CSL_NONE) ? ebcs_pkg::CS_MASK_NONE :
                     (csl_sel == ebcs_pkg::CSL_TWO)  ? ebcs_pkg::CS_MASK_TWO :
                     ebcs_pkg::CS_MASK_THREE;

    // ------------------------------------------------------------
    // Access sequencing
    // ------------------------------------------------------------
    ebcs_pkg::ebcs_state_t state_r, state_nxt;
    ebcs_pkg::ebcs_acc_t   req_r;
    logic [4:0]            hit_r;
    logic                  bus16_r;
    logic [7:0]            low_byte_r;
    logic [15:0]           data_r, data_nxt;
    logic [15:0]           rdat_r, rdat_nxt;
    logic                  rvld_r;

    wire take;
    wire ext_take;
    wire need_split;
    wire a0;
    assign take       = acc_valid && acc_ready;
    assign ext_take   = take && !acc.internal;
    assign need_split = req_r.word && !bus16_r;
    assign a0         = cyc_addr[0];
    assign acc_ready  = (state_r == ebcs_pkg::ST_IDLE);
    assign cyc_req    = (state_r != ebcs_pkg::ST_IDLE);
    assign cyc_write  = req_r.write;
    assign cyc_addr   = (state_r == ebcs_pkg::ST_HIGH) ? {req_r.addr[23:1], 1'b1} : req_r.addr;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ebcs_pkg::ST_IDLE: begin
                if (ext_take) begin
                    state_nxt = ebcs_pkg::ST_LOW;
                end
            end
            ebcs_pkg::ST_LOW: begin
                if (cyc_done) begin
                    state_nxt = need_split ? ebcs_pkg::ST_HIGH : ebcs_pkg::ST_IDLE;
                end
            end
            ebcs_pkg::ST_HIGH: begin
                if (cyc_done) begin
                    state_nxt = ebcs_pkg::ST_IDLE;
                end
            end
            default: state_nxt = ebcs_pkg::ST_IDLE;
        endcase
    end

    // Write data: byte duplicated on a 16-bit bus, high byte shifted down in second half
    wire [7:0] wbyte;
    assign wbyte = acc.addr[0] ? acc.wdata[15:8] : acc.wdata[7:0];
    always_comb begin
        data_nxt = data_r;
        if (ext_take) begin
            data_nxt = acc.word ? acc.wdata : {wbyte, wbyte};
        end else if (state_r == ebcs_pkg::ST_LOW && cyc_done && need_split) begin
            data_nxt = {req_r.wdata[15:8], req_r.wdata[15:8]};
        end
    end

    // Read data: whole word sampled, addressed byte kept
    wire [7:0] sel_byte;
    assign sel_byte = (bus16_r && req_r.addr[0]) ? data_in[15:8] : data_in[7:0];
    always_comb begin
        rdat_nxt = rdat_r;
        if (cyc_done && state_r == ebcs_pkg::ST_LOW && !need_split) begin
            rdat_nxt = req_r.word ? data_in : {8'h00, sel_byte};
        end else if (cyc_done && state_r == ebcs_pkg::ST_HIGH) begin
            rdat_nxt = {data_in[7:0], low_byte_r};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r    <= ebcs_pkg::ST_IDLE;
            req_r      <= '0;
            hit_r      <= 5'h00;
            bus16_r    <= 1'b0;
            low_byte_r <= 8'h00;
            data_r     <= 16'h0000;
            rdat_r     <= 16'h0000;
            rvld_r     <= 1'b0;
        end else begin
            state_r <= state_nxt;
            data_r  <= data_nxt;
            rdat_r  <= rdat_nxt;
            rvld_r  <= cyc_done && !req_r.write && cyc_req && state_nxt == ebcs_pkg::ST_IDLE;
            if (ext_take) begin
                req_r   <= acc;
                hit_r   <= win_hit;
                bus16_r <= cyc_bus16;
            end
            if (cyc_done && state_r == ebcs_pkg::ST_LOW) begin
                low_byte_r <= data_in[7:0];
            end
        end
    end
    assign rd_valid = rvld_r;
    assign rd_data  = rdat_r;
    assign data_out = data_r;
    assign data_oe  = cyc_req && req_r.write;

    // ------------------------------------------------------------
    // Byte lane strobes
    // ------------------------------------------------------------
    wire lo_en;
    wire hi_en;
    assign lo_en = !bus16_r || req_r.word || !a0;
    assign hi_en = bus16_r && (req_r.word || a0);
    assign high_byte_enable_n  = split_write_strobe_cfg ? !(wr_strobe && hi_en)
                                                        : !(cyc_req && hi_en);
    assign write_low_strobe_n  = split_write_strobe_cfg ? !(wr_strobe && lo_en)
                                                        : !wr_strobe;
    assign high_byte_enable_oe = !lane_off_r && hold_acknowledge_n;

    // ------------------------------------------------------------
    // Address ports
    // ------------------------------------------------------------
    logic [7:0] seg_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seg_r <= 8'h00;
        end else if (ext_take) begin
            seg_r <= acc.addr[ebcs_pkg::SEG_LSB +: ebcs_pkg::SEG_W];
        end
    end
    assign seg_addr           = seg_r & seg_mask;
    assign seg_oe             = (strap_sample || !hold_acknowledge_n) ? 8'h00 : seg_mask;
    assign demux_address_port = cyc_addr[15:0];
    assign demux_port_oe      = |win_demux && !strap_sample && hold_acknowledge_n;

    // ------------------------------------------------------------
    // Chip selects
    // ------------------------------------------------------------
    // Boot flag keeps select zero in address mode until the first fetch ends
    logic       boot_r;
    logic [4:0] addr_cs_r;
    logic [4:0] cs_r;
    logic [4:0] cs_nxt;
    wire        any_wr;
    assign any_wr = !write_low_strobe_n || (split_write_strobe_cfg && !high_byte_enable_n);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            boot_r <= 1'b1;
        end else if (strap_sample) begin
            boot_r <= !strap.single_chip;
        end else if (cyc_done) begin
            boot_r <= 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < ebcs_pkg::CS_NUM; gi++) begin : g_cs
            wire addr_mode;
            wire rd_q;
            wire wr_q;
            assign addr_mode = (!sel_write_qualify_bit[gi] && !sel_read_qualify_bit[gi])
                               || (gi == 0 && boot_r);
            assign rd_q = sel_read_qualify_bit[gi] && rd_strobe && !cyc_write;
            assign wr_q = sel_write_qualify_bit[gi] && wr_strobe && any_wr && cyc_write;
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    addr_cs_r[gi] <= 1'b0;
                end else if (ale_fall) begin
                    addr_cs_r[gi] <= hit_r[gi] && cyc_req;
                end
            end
            assign cs_nxt[gi] = addr_mode ? addr_cs_r[gi]
                                          : (hit_r[gi] && cyc_req && (rd_q || wr_q));
        end
    endgenerate

    // Registered so mode changes never spike the pins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_r <= 5'h00;
        end else begin
            cs_r <= cs_nxt;
        end
    end
    assign chip_select_n      = ~cs_r;
    assign chip_select_oe     = (strap_sample || !hold_acknowledge_n) ? 5'h00 : cs_mask;
    assign chip_select_pullup = strap_sample ? cs_mask :
                                !hold_acknowledge_n ? (cs_mask & ~cs_open_drain) : 5'h00;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_internal_no_cyc: assert property (@(posedge clk) disable iff (!nrst)
        (take && acc.internal) |=> !cyc_req)
        else $error("internal access started an external cycle");
    a_byte_dup: assert property (@(posedge clk) disable iff (!nrst)
        (cyc_req && req_r.write && !req_r.word && bus16_r) |-> data_out[15:8] == data_out[7:0])
        else $error("byte write not on both halves");
    a_split_low_first: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == ebcs_pkg::ST_LOW && cyc_done && need_split) |=> cyc_req && cyc_addr[0])
        else $error("second byte cycle missing");
    a_lane_off_rst: assert property (@(posedge clk) disable iff (!nrst)
        $fell(strap_sample) |-> upper_lane_enable_off == !strap_r.bus16)
        else $error("lane-off bit wrong after reset");
    a_hbe_pin_off: assert property (@(posedge clk) disable iff (!nrst)
        upper_lane_enable_off |-> !high_byte_enable_oe)
        else $error("enable pin driven while lane off");
    a_port_release: assert property (@(posedge clk) disable iff (!nrst)
        !(|win_demux) |-> !demux_port_oe)
        else $error("demux port driven without demux window");
    a_addr_cs_stable: assert property (@(posedge clk) disable iff (!nrst)
        (!ale_fall && !$past(ale_fall) && !boot_r && !sel_write_qualify_bit[0]
         && !sel_read_qualify_bit[0] && !$past(sel_write_qualify_bit[0])
         && !$past(sel_read_qualify_bit[0]))
        ##1 (!sel_write_qualify_bit[0] && !sel_read_qualify_bit[0])
        |-> $stable(chip_select_n[0]))
        else $error("address select moved without latch strobe");
    a_rd_cs_strobe: assert property (@(posedge clk) disable iff (!nrst)
        (!boot_r && sel_read_qualify_bit[0] && !sel_write_qualify_bit[0] && !rd_strobe)
        |=> chip_select_n[0])
        else $error("read select active without read strobe");
    a_cs_reset_pull: assert property (@(posedge clk) disable iff (!nrst)
        strap_sample |-> chip_select_oe == 5'h00 && chip_select_pullup == cs_mask)
        else $error("select pins not held by pullups in reset");
    a_hold_float: assert property (@(posedge clk) disable iff (!nrst)
        (!hold_acknowledge_n && !strap_sample) |-> (chip_select_pullup & cs_open_drain) == 5'h00)
        else $error("open-drain select pulled up in hold");

    c_split_word: cover property (@(posedge clk) disable iff (!nrst)
        state_r == ebcs_pkg::ST_HIGH && cyc_done);
    c_byte_read16: cover property (@(posedge clk) disable iff (!nrst)
        rd_valid && bus16_r && !req_r.word);
    c_write_select: cover property (@(posedge clk) disable iff (!nrst)
        !chip_select_n[1] && sel_write_qualify_bit[1] && !sel_read_qualify_bit[1]);
endmodule // ebcs_byte_cs

/* ebcs_far_model.sv */
// Bus sequencer and memory model on the far side of the block
`timescale 1ns/1ns
module ebcs_far_model (
    input  wire logic        clk,       // Clock
    input  wire logic        nrst,      // Reset
    input  wire logic        cyc_req,   // Cycle wanted
    input  wire logic        cyc_write, // Write cycle
    input  wire logic [23:0] cyc_addr,  // Address
    output logic             ale_fall,  // Latch pulse
    output logic             rd_strobe, // Read command
    output logic             wr_strobe, // Write command
    output logic             cyc_done,  // End pulse
    output logic [15:0]      data_in    // Read data
);
    logic [2:0]  ph_r;
    logic [15:0] last_r;
    logic        cmd;
    logic        drv;
    assign cmd       = (ph_r == 3'h3) || (ph_r == 3'h4);
    assign drv       = !cyc_write && (ph_r >= 3'h3);
    assign ale_fall  = ph_r == 3'h1;
    assign rd_strobe = cmd && !cyc_write;
    assign wr_strobe = cmd && cyc_write;
    assign cyc_done  = ph_r == 3'h5;
    // Released bus toggles every cycle so a stale value never matches
    assign data_in   = drv ? {cyc_addr[7:0] ^ 8'h5a, cyc_addr[7:0]} : ~last_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ph_r   <= 3'h0;
            last_r <= 16'h0;
        end else begin
            last_r <= data_in;
            if (ph_r != 3'h0 || cyc_req) ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
        end
    end
endmodule // ebcs_far_model

/* ebcs_byte_cs_bench.sv */
// Self-checking bench for the byte-lane and chip-select block
`timescale 1ns/1ns
module ebcs_byte_cs_bench;
    logic clk, nrst, strap_sample, acc_valid, cyc_bus16, split_write_strobe_cfg, lane_off_we;
    logic lane_off_wdata, hold_acknowledge_n, ale_fall, rd_strobe, wr_strobe, cyc_done;
    logic acc_ready, rd_valid, cyc_req, cyc_write, upper_lane_enable_off, high_byte_enable_n;
    logic high_byte_enable_oe, write_low_strobe_n, data_oe, demux_port_oe;
    logic req_seen, hbe_low, wrl_low;
    logic [4:0] win_hit, win_demux, sel_write_qualify_bit, sel_read_qualify_bit, cs_open_drain;
    logic [4:0] chip_select_n, chip_select_oe, chip_select_pullup, cs_low, pre;
    logic [7:0] seg_addr, seg_oe, seg_s, segoe_s;
    logic [15:0] data_in, rd_data, data_out, demux_address_port, rd_s, do_s;
    logic [23:0] cyc_addr;
    ebcs_pkg::ebcs_strap_t strap;
    ebcs_pkg::ebcs_acc_t acc;
    int bad_count, checks_done;
    localparam logic [7:0] SM [4] = '{8'h0f, 8'h00, 8'hff, 8'h03};
    localparam logic [4:0] CM [4] = '{5'h07, 5'h03, 5'h00, 5'h1f};
    ebcs_byte_cs dut (.clk, .nrst, .strap_sample, .strap, .acc_valid, .acc, .win_hit, .win_demux,
        .sel_write_qualify_bit, .sel_read_qualify_bit, .cyc_bus16, .split_write_strobe_cfg,
        .lane_off_we, .lane_off_wdata, .ale_fall, .rd_strobe, .wr_strobe, .cyc_done, .data_in,
        .hold_acknowledge_n, .cs_open_drain, .acc_ready, .rd_valid, .rd_data, .cyc_req,
        .cyc_write, .cyc_addr, .upper_lane_enable_off, .high_byte_enable_n, .high_byte_enable_oe,
        .write_low_strobe_n, .data_out, .data_oe, .seg_addr, .seg_oe, .chip_select_n,
        .chip_select_oe, .chip_select_pullup, .demux_address_port, .demux_port_oe);
    ebcs_far_model far (.clk, .nrst, .cyc_req, .cyc_write, .cyc_addr, .ale_fall, .rd_strobe,
        .wr_strobe, .cyc_done, .data_in);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // --------------------------------
    // Pin activity seen during a cycle
    // --------------------------------
    always @(posedge clk) begin
        if (cyc_req) begin
            req_seen = 1'b1;
            cs_low   = cs_low | ~chip_select_n;
            hbe_low  = hbe_low | !high_byte_enable_n;
            wrl_low  = wrl_low | !write_low_strobe_n;
            seg_s    = seg_addr;
            segoe_s  = seg_oe;
            do_s     = data_out;
        end
        if (ale_fall) pre = pre | ~chip_select_n;
        if (rd_valid) rd_s = rd_data;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (e !== g) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    task automatic go(input logic [23:0] a, input logic [15:0] d, input logic wr, wd, inl);
        int n;
        {req_seen, hbe_low, wrl_low, cs_low, pre} = '0;
        acc = '{a, d, wr, wd, inl};
        acc_valid = 1'b1;
        @(posedge clk);
        #1 acc_valid = 1'b0;
        n = 0;
        repeat (2) @(posedge clk);
        #1;
        while (cyc_req && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 40) bad_count++;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_reset(input logic [1:0] c, input logic b16);
        nrst = 1'b0;
        strap_sample = 1'b1;
        strap = '{c, c, b16, 1'b0};
        repeat (6) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("pullup", CM[c], chip_select_pullup);
        chk("oe_rst", 0, chip_select_oe);
        chk("lane_off_rst", !b16, upper_lane_enable_off);
        strap_sample = 1'b0;
        @(posedge clk);
        #1 chk("cs_oe", CM[c], chip_select_oe);
    endtask
    task automatic t_straps();
        for (int i = 0; i < 4; i++) begin
            t_reset(i[1:0], i[0]);
            go(24'hab_1234, 16'h0, 1'b0, 1'b1, 1'b0);
            chk("seg_oe", SM[i], segoe_s);
            chk("seg_addr", 8'hab & SM[i], seg_s);
        end
        $display("test straps done");
    endtask
    task automatic t_boot();
        sel_read_qualify_bit = 5'h01;
        go(24'h00_0100, 16'h1234, 1'b1, 1'b1, 1'b0);
        chk("boot_cs0", 1, cs_low[0]);
        go(24'h00_0100, 16'h1234, 1'b1, 1'b1, 1'b0);
        chk("rd_sel_wr", 0, cs_low[0]);
        sel_read_qualify_bit = 5'h00;
        $display("test boot done");
    endtask
    task automatic t_lanes();
        go(24'h02_3456, 16'h0, 1'b0, 1'b1, 1'b0);
        chk("word_rd", 16'h0c56, rd_s);
        chk("port_addr", 16'h3456, demux_address_port);
        chk("hbe_word", 1, hbe_low);
        chk("seg_lines", 8'h02, seg_s);
        chk("cs_in", 1, cs_low[0]);
        chk("port_free", 0, demux_port_oe);
        win_demux = 5'h04;
        #4 chk("port_used", 1, demux_port_oe);
        go(24'h00_0031, 16'h0, 1'b0, 1'b0, 1'b0);
        chk("byte_hi", 16'h006b, rd_s);
        go(24'h00_0030, 16'h0, 1'b0, 1'b0, 1'b0);
        chk("byte_lo", 16'h0030, rd_s);
        chk("hbe_even", 0, hbe_low);
        split_write_strobe_cfg = 1'b1;
        go(24'h00_0032, 16'h00c3, 1'b1, 1'b0, 1'b0);
        chk("dup_lo", 16'hc3c3, do_s);
        chk("strobe_lo", 2'b01, {hbe_low, wrl_low});
        go(24'h00_0033, 16'h5a00, 1'b1, 1'b0, 1'b0);
        chk("dup_hi", 16'h5a5a, do_s);
        chk("strobe_hi", 2'b10, {hbe_low, wrl_low});
        split_write_strobe_cfg = 1'b0;
        cyc_bus16 = 1'b0;
        go(24'h00_0040, 16'h0, 1'b0, 1'b1, 1'b0);
        chk("w8_rd", 16'h4140, rd_s);
        go(24'h00_0050, 16'hbeef, 1'b1, 1'b1, 1'b0);
        chk("w8_wr", 16'hbebe, do_s);
        cyc_bus16 = 1'b1;
        $display("test lanes done");
    endtask
    task automatic t_modes();
        logic [1:0] m;
        win_hit = 5'h02;
        for (int i = 3; i >= 0; i--) begin
            m = i[1:0];
            {sel_write_qualify_bit[1], sel_read_qualify_bit[1]} = m;
            for (int w = 0; w < 2; w++) begin
                go(24'h01_0000, 16'h1111, w[0], 1'b1, 1'b0);
                chk("cs_mode", m == 2'h0 || m[w], cs_low[1]);
                chk("cs_at_ale", m == 2'h0, pre[1]);
            end
        end
        chk("cs_stand", 0, chip_select_n[1]);
        win_hit = 5'h04;
        go(24'h03_0000, 16'h0, 1'b0, 1'b1, 1'b0);
        chk("cs_moved", 2'b01, chip_select_n[2:1]);
        go(24'h00_f000, 16'h0, 1'b0, 1'b1, 1'b1);
        chk("internal", 0, req_seen);
        chk("cs_kept", 0, chip_select_n[2]);
        $display("test modes done");
    endtask
    task automatic t_pins();
        chk("hbe_pin_on", 1, high_byte_enable_oe);
        cs_open_drain = 5'h05;
        hold_acknowledge_n = 1'b0;
        #8 chk("hold_oe", 0, chip_select_oe);
        chk("hold_pu", 5'h1a, chip_select_pullup);
        hold_acknowledge_n = 1'b1;
        lane_off_wdata = 1'b1;
        lane_off_we = 1'b1;
        #4 lane_off_we = 1'b0;
        chk("lane_off", 1, upper_lane_enable_off);
        chk("hbe_pin", 0, high_byte_enable_oe);
        $display("test pins done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        end_of_test();
    end
    initial begin
        {nrst, strap_sample, acc_valid, lane_off_we, lane_off_wdata} = '0;
        {split_write_strobe_cfg, win_demux, sel_write_qualify_bit} = '0;
        {sel_read_qualify_bit, cs_open_drain, acc} = '0;
        {hold_acknowledge_n, cyc_bus16, win_hit} = 7'h61;
        strap = ebcs_pkg::STRAP_RST;
        bad_count = 0;
        checks_done = 0;
        t_straps();
        t_reset(2'h3, 1'b1);
        t_boot();
        t_lanes();
        t_modes();
        t_pins();
        end_of_test();
    end
endmodule // ebcs_byte_cs_bench
